// ### arb_table_pkg.sv
/*
 * shared constants and types for the port arbitration phase table:
 * register offsets, reset contents, slot encoding and bus carriers.
 * assumes an axi4-lite master with 32-bit data and 12-bit byte addresses.
 */
// Notes on behaviour
// - each phase is a 4-bit port slot, eight per word, phase 0 lowest
// - a slot naming an invalid port is skipped at once, costing no period
// - codes zero, two, four and six select ports 0, 2, 4 and 6
// - odd codes and codes eight to fifteen are reserved, never valid ports
// - pending bit sets on an upstream table write with any strobe set, clears when load completes or while downstream
// - load bit copies table into arbiter on the upstream port only, writing zero does nothing, reads 0
package arb_table_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_PHASES_0_TO_7 = 12'h220;
    localparam logic [11:0] ADDR_PHASES_8_TO_15 = 12'h224;
    localparam logic [11:0] ADDR_LOAD_CTL = 12'h214;
    localparam logic [11:0] ADDR_LOAD_STS = 12'h218;
    localparam int LOAD_BIT = 16;
    localparam int PENDING_BIT = 16;

    localparam logic [31:0] RESET_PHASES_0_TO_7 = 32'h4264_2642;
    localparam logic [31:0] RESET_PHASES_8_TO_15 = 32'h2642_6426;

    // ------------------------------------------------------------------
    // slot layout and encoding
    // ------------------------------------------------------------------
    localparam int SLOT_BITS = 4;
    localparam int NUM_PHASES = 16;
    localparam int PHASE_BITS = 4;
    localparam int LOAD_CYCLES = 2;
    localparam logic [3:0] PORT_CODE_MAX = 4'h6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic [3:0] port;
        logic [3:0] phase;
    } grant_t;

    typedef enum {LOAD_IDLE, LOAD_COPY} load_state_t;

endpackage

// ### phase_table_mem.sv
/*
 * active arbitration table: sixteen 4-bit slots held in flops, loaded
 * as a whole from the shadow words, read out through a register.
 * assumes the loader holds load high only for a single cycle.
 */
`timescale 1ns/1ps
module phase_table_mem
    import arb_table_pkg::*;
#(
    parameter int DEPTH = NUM_PHASES
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [DEPTH*SLOT_BITS-1:0] shadow_i,
    input wire logic [PHASE_BITS-1:0] rd_phase_i,
    output logic [SLOT_BITS-1:0] rd_port_o
);
    logic [DEPTH*SLOT_BITS-1:0] active;
    wire [SLOT_BITS-1:0] sel_slot = active[rd_phase_i*SLOT_BITS +: SLOT_BITS];

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active <= {RESET_PHASES_8_TO_15, RESET_PHASES_0_TO_7};
            rd_port_o <= '0;
        end
        else
        begin
            if (load_i)
                active <= shadow_i;
            rd_port_o <= sel_slot;
        end
    end
endmodule

// ### port_arbitration_phase_table.sv
/*
 * port arbitration phase table for phases 0 to 15 with its axi4-lite
 * register slave, load control, pending status and the phase walker
 * that hands one granted port per arbitration period to the engine.
 * assumes the engine raises period_done_i for one cycle when a
 * period ends and that this instance sits on the upstream port
 * unless upstream_i is low.
 */
`timescale 1ns/1ps
module port_arbitration_phase_table
    import arb_table_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic upstream_i,
    input wire logic period_done_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output grant_t grant_o
);
    // ------------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------------
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] word0, word1;
    logic pending;
    load_state_t load_state;
    logic [1:0] load_cnt;

    wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take = s_axi_wvalid_i && s_axi_wready_o;
    wire do_write = aw_held && w_held && !s_axi_bvalid_o;
    wire wr_t0 = do_write && aw_addr == ADDR_PHASES_0_TO_7;
    wire wr_t1 = do_write && aw_addr == ADDR_PHASES_8_TO_15;
    wire wr_ctl = do_write && aw_addr == ADDR_LOAD_CTL;
    wire wr_sts = do_write && aw_addr == ADDR_LOAD_STS;
    wire wr_ok = wr_t0 || wr_t1 || wr_ctl || wr_sts;
    wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                             {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] next_word0 = (word0 & ~strb_mask) | (w_data & strb_mask);
    wire [31:0] next_word1 = (word1 & ~strb_mask) | (w_data & strb_mask);
    wire table_write = (wr_t0 || wr_t1) && (|w_strb);
    wire load_req = wr_ctl && w_strb[LOAD_BIT/8] && w_data[LOAD_BIT]
                    && upstream_i;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready_o <= !aw_held && !aw_take && !s_axi_bvalid_o;
            s_axi_wready_o <= !w_held && !w_take && !s_axi_bvalid_o;
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr_i[11:2], 2'b00};
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // shadow table words
    // ------------------------------------------------------------------
    // eight nibble slots per word
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            word0 <= RESET_PHASES_0_TO_7;
            word1 <= RESET_PHASES_8_TO_15;
        end
        else
        begin
            if (wr_t0)
                word0 <= next_word0;
            if (wr_t1)
                word1 <= next_word1;
        end
    end

    // ------------------------------------------------------------------
    // load sequencer and pending status
    // ------------------------------------------------------------------
    wire load_pulse = load_state == LOAD_COPY && load_cnt == '0;
    wire load_done = load_state == LOAD_COPY
                     && load_cnt == 2'(LOAD_CYCLES - 1);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            load_state <= LOAD_IDLE;
            load_cnt <= '0;
            pending <= 1'b0;
        end
        else
        begin
            case (load_state)
                LOAD_IDLE:
                begin
                    load_cnt <= '0;
                    if (load_req)
                        load_state <= LOAD_COPY;
                end
                LOAD_COPY:
                begin
                    load_cnt <= load_cnt + 2'd1;
                    if (load_done)
                        load_state <= LOAD_IDLE;
                end
                default: load_state <= LOAD_IDLE;
            endcase
            // write sets, finish clears; a write wins the tie
            if (table_write && upstream_i)
                pending <= 1'b1;
            else if (load_done || !upstream_i)
                pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
    wire [11:0] ar_addr = {s_axi_araddr_i[11:2], 2'b00};
    wire rd_hit = ar_addr == ADDR_PHASES_0_TO_7
                  || ar_addr == ADDR_PHASES_8_TO_15
                  || ar_addr == ADDR_LOAD_CTL || ar_addr == ADDR_LOAD_STS;
    wire [31:0] rd_word =
        ar_addr == ADDR_PHASES_0_TO_7 ? word0 :
        ar_addr == ADDR_PHASES_8_TO_15 ? word1 :
        ar_addr == ADDR_LOAD_STS ? 32'(pending) << PENDING_BIT : 32'h0;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_rvalid_o && !ar_take;
            if (ar_take)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // phase walker
    // ------------------------------------------------------------------
    logic [PHASE_BITS-1:0] phase;
    logic [SLOT_BITS-1:0] slot_port;
    logic walk_live;

    phase_table_mem #(.DEPTH(NUM_PHASES)) u_mem (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(load_pulse),
        .shadow_i({word1, word0}),
        .rd_phase_i(phase),
        .rd_port_o(slot_port)
    );

    // even codes up to six are ports, rest reserved
    wire slot_valid = !slot_port[0] && slot_port <= PORT_CODE_MAX;
    // invalid slot advances next cycle without a grant
    wire advance = walk_live && (!slot_valid || period_done_i);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase <= '0;
            walk_live <= 1'b0;
            grant_o <= '0;
        end
        else
        begin
            if (load_pulse)
                phase <= '0;
            else if (advance)
                phase <= phase + 4'd1;
            // slot read lags the phase by a cycle: wait until it lands
            walk_live <= !advance && !load_pulse;
            grant_o.valid <= walk_live && slot_valid && !advance
                             && !load_pulse;
            grant_o.port <= slot_port;
            grant_o.phase <= phase;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_no_reserved_grant;
        @(posedge core_clk_i) disable iff (rst_i)
        grant_o.valid |-> !grant_o.port[0] && grant_o.port <= PORT_CODE_MAX;
    endproperty
    a_no_reserved_grant: assert property (p_no_reserved_grant)
        else $error("grant on reserved port code");

    property p_pending_sets;
        @(posedge core_clk_i) disable iff (rst_i)
        table_write && upstream_i |=> pending;
    endproperty
    a_pending_sets: assert property (p_pending_sets)
        else $error("pending not set after table write");

    sequence s_load_started;
        load_req && load_state == LOAD_IDLE;
    endsequence
    property p_load_clears;
        @(posedge core_clk_i) disable iff (rst_i)
        s_load_started ##1 !table_write [*2] |=> !pending;
    endproperty
    a_load_clears: assert property (p_load_clears)
        else $error("pending still set after load");

    property p_downstream_quiet;
        @(posedge core_clk_i) disable iff (rst_i)
        !upstream_i |=> !pending && load_state == LOAD_IDLE;
    endproperty
    a_downstream_quiet: assert property (p_downstream_quiet)
        else $error("pending or load active on downstream port");

    property p_skip_fast;
        @(posedge core_clk_i) disable iff (rst_i)
        walk_live && !slot_valid && !load_pulse
            |=> phase == $past(phase) + 4'd1;
    endproperty
    a_skip_fast: assert property (p_skip_fast)
        else $error("invalid slot not skipped at once");

    property p_period_steps;
        @(posedge core_clk_i) disable iff (rst_i)
        walk_live && period_done_i && !load_pulse
            |=> phase == $past(phase) + 4'd1 && !grant_o.valid;
    endproperty
    a_period_steps: assert property (p_period_steps)
        else $error("phase did not step after period end");

    property p_grant_holds;
        @(posedge core_clk_i) disable iff (rst_i)
        grant_o.valid && !period_done_i && !load_pulse
            |=> grant_o.valid && $stable(grant_o.phase);
    endproperty
    a_grant_holds: assert property (p_grant_holds)
        else $error("grant dropped before its period ended");

    property p_ctl_reads_zero;
        @(posedge core_clk_i) disable iff (rst_i)
        ar_take && ar_addr == ADDR_LOAD_CTL |=> s_axi_rdata_o == 32'h0;
    endproperty
    a_ctl_reads_zero: assert property (p_ctl_reads_zero)
        else $error("load control read not zero");
endmodule

// ### testbench.sv
/*
 * self-checking bench for the phase table: axi4-lite register tasks,
 * pending and load checks, and a walk of the granted phases.
 * assumes the package and the table design are compiled ahead of it.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench
    import arb_table_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic upstream_i = 1'b1;
    logic period_done_i = 1'b0;
    logic [11:0] s_axi_awaddr_i = 12'h000;
    logic s_axi_awvalid_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0;
    logic [11:0] s_axi_araddr_i = 12'h000;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    grant_t grant_o;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [31:0] PEND_MASK = 32'h0000_0001 << PENDING_BIT;
    localparam logic [31:0] LOAD_MASK = 32'h0000_0001 << LOAD_BIT;

    port_arbitration_phase_table dut (.core_clk_i, .rst_i, .upstream_i,
        .period_done_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .grant_o);

    always #50 core_clk_i = ~core_clk_i;

    // ------------------------------------------------------------------
    // closing report and hang guard
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        forever
        begin
            @(posedge core_clk_i);
            if (!aw_ok && s_axi_awready_o === 1'b1)
            begin
                aw_ok = 1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w_ok && s_axi_wready_o === 1'b1)
            begin
                w_ok = 1;
                s_axi_wvalid_i <= 1'b0;
            end
            if (s_axi_bvalid_o === 1'b1)
            begin
                `CHK("bresp", er, s_axi_bresp_o)
                s_axi_bready_i <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er);
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        forever
        begin
            @(posedge core_clk_i);
            if (s_axi_arready_o === 1'b1)
                s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1)
            begin
                `CHK("rdata", e, s_axi_rdata_o & m)
                `CHK("rresp", er, s_axi_rresp_o)
                s_axi_rready_i <= 1'b0;
                break;
            end
        end
    endtask

    // only even codes below eight name a port
    function automatic logic legal(input logic [3:0] c);
        return c[0] == 1'b0 && c < 4'h8;
    endfunction

    // follows the grants from phase st, ending each period by a pulse
    task automatic walk(input logic [63:0] tb, input int st, input int n);
        int ph;
        ph = st;
        for (int i = 0; i < n; i++)
        begin
            // bounded, so an all-reserved table cannot hang in zero time
            for (int j = 0; j < NUM_PHASES; j++)
                if (!legal(tb[ph*4 +: 4]))
                    ph = (ph + 1) % NUM_PHASES;
            for (int k = 0; k < 40; k++)
            begin
                @(posedge core_clk_i);
                if (grant_o.valid === 1'b1 && grant_o.phase === ph[3:0])
                    break;
            end
            `CHK("grant_valid", 1'b1, grant_o.valid)
            `CHK("grant_phase", ph[3:0], grant_o.phase)
            `CHK("grant_port", tb[ph*4 +: 4], grant_o.port)
            period_done_i <= 1'b1;
            @(posedge core_clk_i);
            period_done_i <= 1'b0;
            ph = (ph + 1) % NUM_PHASES;
        end
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rd_chk(ADDR_PHASES_0_TO_7, '1, 32'h4264_2642, RESP_OKAY);
        rd_chk(ADDR_PHASES_8_TO_15, '1, 32'h2642_6426, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        walk({32'h2642_6426, 32'h4264_2642}, 0, 4);
        $display("test reset_contents done");
        // each code once: phase n of the first word holds code n
        wr(ADDR_PHASES_0_TO_7, 32'h7654_3210, 4'hF, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, PEND_MASK, RESP_OKAY);
        wr(ADDR_PHASES_8_TO_15, 32'hFEDC_BA98, 4'hF, RESP_OKAY);
        rd_chk(ADDR_PHASES_0_TO_7, '1, 32'h7654_3210, RESP_OKAY);
        rd_chk(ADDR_PHASES_8_TO_15, '1, 32'hFEDC_BA98, RESP_OKAY);
        wr(ADDR_LOAD_CTL, 32'h0, 4'hF, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, PEND_MASK, RESP_OKAY);
        wr(ADDR_LOAD_CTL, LOAD_MASK, 4'hF, RESP_OKAY);
        rd_chk(ADDR_LOAD_CTL, LOAD_MASK, 32'h0, RESP_OKAY);
        repeat (LOAD_CYCLES + 1) @(posedge core_clk_i);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        walk({32'hFEDC_BA98, 32'h7654_3210}, 0, 6);
        $display("test load_and_skip done");
        wr(12'h300, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd_chk(12'h300, '1, 32'h0, RESP_SLVERR);
        wr(ADDR_PHASES_0_TO_7, 32'h0000_00AA, 4'h1, RESP_OKAY);
        rd_chk(ADDR_PHASES_0_TO_7, '1, 32'h7654_32AA, RESP_OKAY);
        // status is read-only: a write must not clear the pending bit
        wr(ADDR_LOAD_STS, 32'h0, 4'hF, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, PEND_MASK, RESP_OKAY);
        $display("test unmapped_and_strobe done");
        // a downstream instance keeps its active table on a load
        upstream_i <= 1'b0;
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        wr(ADDR_LOAD_CTL, LOAD_MASK, 4'hF, RESP_OKAY);
        wr(ADDR_PHASES_8_TO_15, 32'h2642_6426, 4'hF, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        walk({32'hFEDC_BA98, 32'h7654_3210}, 4, 2);
        $display("test downstream done");
        // a reset in mid-run restores the table and leaves nothing pending
        rst_i <= 1'b1;
        upstream_i <= 1'b1;
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rd_chk(ADDR_PHASES_0_TO_7, '1, 32'h4264_2642, RESP_OKAY);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        // only ports 2, 4 and 6: no reserved code and no egress port 0
        wr(ADDR_PHASES_0_TO_7, 32'h2466_4424, 4'hF, RESP_OKAY);
        wr(ADDR_LOAD_CTL, LOAD_MASK, 4'hF, RESP_OKAY);
        repeat (LOAD_CYCLES + 1) @(posedge core_clk_i);
        rd_chk(ADDR_LOAD_STS, PEND_MASK, 32'h0, RESP_OKAY);
        walk({32'h2642_6426, 32'h2466_4424}, 0, 3);
        $display("test reset_and_reload done");
        report_and_stop();
    end
endmodule
